/* inc/bbsd_pkg.sv */
package bbsd_pkg;
  // ----------------------------------------
  // opcode fields
  // ----------------------------------------
  localparam logic [3:0] RJMP_TOP  = 4'hd;
  localparam logic [3:0] BSET_TOP  = 4'h8;
  localparam logic [3:0] TSKC_TOP  = 4'hb;
  localparam logic [3:0] TSKS_TOP  = 4'ha;
  localparam int         OFS_W     = 11;
  localparam int         PC_W      = 21;
  localparam int         BIT_LSB   = 9;
  localparam int         ACC_POS   = 8;
  localparam int         RJMP_SEL  = 11;
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_BANK  = 4'hf;
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;

  // ----------------------------------------
  // phase steps of one instruction cycle
  // ----------------------------------------
  typedef enum logic [1:0] {
    BBSD_Q1 = 2'b00,
    BBSD_Q2 = 2'b01,
    BBSD_Q3 = 2'b10,
    BBSD_Q4 = 2'b11
  } bbsd_phase_t;

  typedef enum logic [2:0] {
    BBSD_NONE = 3'b000,
    BBSD_RJMP = 3'b001,
    BBSD_BSET = 3'b010,
    BBSD_TSKC = 3'b011,
    BBSD_TSKS = 3'b100
  } bbsd_op_t;
endpackage

/* rtl/bbsd_core.sv */
`timescale 1ns/1ps
// Overview of operation
// - relative jump: top nibble 1101, bit11 zero, signed 11-bit offset
// - jump target is the captured fetch address plus twice the offset
// - relative jump takes two cycles, second cycle does nothing
// - bit set: 1000, 3-bit index, bank flag, 8-bit file address
// - bit set reads file register, forces chosen bit, writes back
// - bit set and jump never touch arithmetic status flags
// - bank flag 0 selects access bank, 1 uses bank select register
// - flag 0, extended set on, address <= 5Fh gives indexed literal offset
module bbsd_core
  import bbsd_pkg::*;
(
  input  wire logic            mclk_i,
  input  wire logic            rst_i,
  input  wire logic            instr_valid_i,
  input  wire logic [15:0]     instr_i,
  input  wire logic [PC_W-1:0] fetch_pc_i,
  input  wire logic [3:0]      bank_select_reg_i,
  input  wire logic            ext_set_en_i,
  input  wire logic [11:0]     index_base_i,
  input  wire logic [7:0]      file_rdata_i,
  output logic                 busy_o,
  output logic                 pc_load_o,
  output logic [PC_W-1:0]      pc_target_o,
  output logic                 file_re_o,
  output logic                 file_we_o,
  output logic [11:0]          file_addr_o,
  output logic [7:0]           file_wdata_o,
  output logic                 skip_next_o,
  output logic                 status_we_o
);
  // ----------------------------------------
  // decode of the captured word
  // ----------------------------------------
  bbsd_phase_t     phase_q;
  bbsd_op_t        op_q;
  logic [15:0]     ir_q;
  logic [PC_W-1:0] base_q;
  logic            nop_cycle_q;
  bbsd_op_t        op_d;
  logic [2:0]      bit_sel;
  logic [11:0]     eff_addr;
  logic [PC_W-1:0] ofs_ext;
  logic [7:0]      set_val;
  logic            at_q1;
  logic            at_q2;
  logic            at_q4;
  logic            is_jump;
  logic            is_file_op;
  logic            take_word;

  // unlisted top nibbles belong to other decoders and leave this block idle
  always_comb begin
    op_d = BBSD_NONE;
    unique case (instr_i[15:12])
      RJMP_TOP: begin
        if (!instr_i[RJMP_SEL]) begin
          op_d = BBSD_RJMP;
        end
      end
      BSET_TOP: begin
        op_d = BBSD_BSET;
      end
      TSKC_TOP: begin
        op_d = BBSD_TSKC;
      end
      TSKS_TOP: begin
        op_d = BBSD_TSKS;
      end
      default: begin
        op_d = BBSD_NONE;
      end
    endcase
  end

  // ----------------------------------------
  // operand fields
  // ----------------------------------------
  assign bit_sel = ir_q[BIT_LSB+2:BIT_LSB];
  // sign extend then double: offset n spans -1024..1023
  assign ofs_ext = {{(PC_W-OFS_W-1){ir_q[OFS_W-1]}}, ir_q[OFS_W-1:0], 1'b0};
  assign set_val = file_rdata_i | (8'h01 << bit_sel);

  // ----------------------------------------
  // file address resolution
  // ----------------------------------------
  // indexed sum wraps inside the 12-bit file space, no carry out is kept
  always_comb begin
    if (!ir_q[ACC_POS] && ext_set_en_i && ir_q[7:0] <= IDX_LIMIT) begin
      eff_addr = index_base_i + {4'h0, ir_q[7:0]};
    end else if (!ir_q[ACC_POS]) begin
      eff_addr = (ir_q[7:0] < ACC_SPLIT) ? {4'h0, ir_q[7:0]} : {ACC_BANK, ir_q[7:0]};
    end else begin
      eff_addr = {bank_select_reg_i, ir_q[7:0]};
    end
  end

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  assign at_q1      = (phase_q == BBSD_Q1);
  assign at_q2      = (phase_q == BBSD_Q2);
  assign at_q4      = (phase_q == BBSD_Q4);
  assign is_jump    = (op_q == BBSD_RJMP);
  assign is_file_op = (op_q == BBSD_BSET) || (op_q == BBSD_TSKC) || (op_q == BBSD_TSKS);
  // a word offered in the jump's dead cycle is dropped, never queued
  assign take_word  = at_q1 && instr_valid_i && !nop_cycle_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      phase_q <= BBSD_Q1;
    end else begin
      phase_q <= bbsd_phase_t'(phase_q + 2'b01);
    end
  end

  // op code lives for one instruction cycle, from one Q1 to the next
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      op_q <= BBSD_NONE;
    end else if (at_q1) begin
      if (take_word) begin
        op_q <= op_d;
      end else begin
        op_q <= BBSD_NONE;
      end
    end
  end

  // operand and fetch address move only when a word is taken
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ir_q   <= 16'h0000;
      base_q <= PC_RST;
    end else if (take_word) begin
      ir_q   <= instr_i;
      base_q <= fetch_pc_i;
    end
  end

  // raised at the end of the jump's own cycle, dropped one cycle later
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      nop_cycle_q <= 1'b0;
    end else if (at_q4) begin
      nop_cycle_q <= is_jump && !nop_cycle_q;
    end
  end

  // ----------------------------------------
  // outputs, each from its own flip-flop
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= nop_cycle_q || is_jump;
    end
  end

  // target stays on the port after the pulse for a late reader
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pc_load_o   <= 1'b0;
      pc_target_o <= PC_RST;
    end else if (at_q4 && is_jump) begin
      pc_load_o   <= 1'b1;
      pc_target_o <= base_q + ofs_ext;
    end else begin
      pc_load_o <= 1'b0;
    end
  end

  // read in Q2 leaves the memory a full phase before Q4 uses the data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      file_re_o   <= 1'b0;
      file_addr_o <= 12'h000;
    end else if (at_q2 && is_file_op) begin
      file_re_o   <= 1'b1;
      file_addr_o <= eff_addr;
    end else begin
      file_re_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      file_we_o    <= 1'b0;
      file_wdata_o <= 8'h00;
    end else if (at_q4 && op_q == BBSD_BSET) begin
      file_we_o    <= 1'b1;
      file_wdata_o <= set_val;
    end else begin
      file_we_o <= 1'b0;
    end
  end

  // skip is only a pulse: the consumer discards the word already fetched
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      skip_next_o <= 1'b0;
    end else if (at_q4) begin
      unique case (op_q)
        BBSD_TSKC: begin
          skip_next_o <= !file_rdata_i[bit_sel];
        end
        BBSD_TSKS: begin
          skip_next_o <= file_rdata_i[bit_sel];
        end
        BBSD_NONE, BBSD_RJMP, BBSD_BSET: begin
          skip_next_o <= 1'b0;
        end
        default: begin
          skip_next_o <= 1'b0;
        end
      endcase
    end else begin
      skip_next_o <= 1'b0;
    end
  end

  // none of these operations ever write arithmetic flags
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status_we_o <= 1'b0;
    end else begin
      status_we_o <= 1'b0;
    end
  end
endmodule

/* testbench/bbsd_monitor.sv */
`timescale 1ns/1ps
module bbsd_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic busy_o,
  input wire logic pc_load_o,
  input wire logic file_re_o,
  input wire logic file_we_o,
  input wire logic skip_next_o,
  input wire logic status_we_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence nop_s;
    busy_o && !file_re_o && !file_we_o;
  endsequence
  stat_quiet_a: assert property (!status_we_o) else $error("status write");
  jump_busy_a: assert property (pc_load_o |-> busy_o && $past(busy_o, 2))
    else $error("load outside busy");
  jump_nop_a: assert property (pc_load_o |=> nop_s [*4] ##1 !busy_o)
    else $error("second cycle not idle");
  load_gap_a: assert property (pc_load_o |=> !pc_load_o [*7]) else $error("load gap");
  set_read_a: assert property (file_we_o |-> $past(file_re_o, 2) && !busy_o)
    else $error("write without read");
  set_pulse_a: assert property (file_we_o |=> !file_we_o) else $error("long write");
  skip_read_a: assert property (skip_next_o |-> $past(file_re_o, 2))
    else $error("skip without read");
  skip_pure_a: assert property (skip_next_o |-> !file_we_o && !pc_load_o)
    else $error("skip side effect");
endmodule

/* testbench/branch_and_bit_set_decode_tb_top.sv */
`timescale 1ns/1ps
module branch_and_bit_set_decode_tb_top;
  import bbsd_pkg::*;
  logic mclk_i = 0, rst_i = 1, instr_valid_i = 0, ext_set_en_i = 0;
  logic [15:0] instr_i = 0;
  logic [PC_W-1:0] fetch_pc_i = 0, pc_target_o;
  logic [3:0] bank_select_reg_i = 0;
  logic [11:0] index_base_i = 0, file_addr_o;
  logic [7:0] file_rdata_i = 0, file_wdata_o;
  logic busy_o, pc_load_o, file_re_o, file_we_o, skip_next_o, status_we_o;
  int mismatches = 0, n_compared = 0, cyc = 0;
  always #4 mclk_i = ~mclk_i;
  bbsd_core u_dut (.*);
  task end_of_test;
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task ck(input logic ok);
    n_compared++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("FAIL %0t word %h", $time, instr_i);
    end
  endtask
  // eight cycles a word, so a repeat take in the idle half never overlaps checks
  task slot(input logic v, input logic [15:0] w, input logic [7:0] rd, input logic re,
            input logic [11:0] ea, input logic ld, input logic [PC_W-1:0] tg,
            input logic we, input logic [7:0] wd, input logic sk);
    instr_valid_i <= v;
    instr_i <= w;
    file_rdata_i <= rd;
    repeat (3) @(negedge mclk_i);
    ck(file_re_o === re && (!re || file_addr_o === ea));
    repeat (2) @(negedge mclk_i);
    ck(pc_load_o === ld && (!ld || pc_target_o === tg) && file_we_o === we && busy_o === ld
       && (!we || file_wdata_o === wd) && skip_next_o === sk && status_we_o === 1'b0);
    repeat (4) @(posedge mclk_i);
  endtask
  task t_jump;
    fetch_pc_i <= 21'h001000;
    slot(1, 16'hd400, 0, 0, 0, 1, 21'h000800, 0, 0, 0);
    fetch_pc_i <= 21'h000100;
    slot(1, 16'hd3ff, 0, 0, 0, 1, 21'h0008fe, 0, 0, 0);
    slot(1, 16'hdc00, 0, 0, 0, 0, 0, 0, 0, 0);
  endtask
  task t_bset;
    bank_select_reg_i <= 4'h3;
    slot(1, 16'h8f20, 8'h0a, 1, 12'h320, 0, 0, 1, 8'h8a, 0);
    slot(1, 16'h8010, 8'h00, 1, 12'h010, 0, 0, 1, 8'h01, 0);
    ext_set_en_i <= 1;
    index_base_i <= 12'h100;
    slot(1, 16'h805f, 8'hfe, 1, 12'h15f, 0, 0, 1, 8'hff, 0);
    slot(1, 16'h8660, 8'h00, 1, 12'hf60, 0, 0, 1, 8'h08, 0);
  endtask
  task t_skip;
    slot(1, 16'hb544, 8'hfb, 1, 12'h344, 0, 0, 0, 0, 1);
    slot(1, 16'hb544, 8'h04, 1, 12'h344, 0, 0, 0, 0, 0);
    slot(1, 16'ha544, 8'h04, 1, 12'h344, 0, 0, 0, 0, 1);
    slot(1, 16'ha544, 8'hfb, 1, 12'h344, 0, 0, 0, 0, 0);
  endtask
  task t_idle;
    slot(0, 16'h8f20, 8'h00, 0, 0, 0, 0, 0, 0, 0);
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 400) begin
      mismatches++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 0;
    t_jump;
    t_bset;
    t_skip;
    t_idle;
    end_of_test;
  end
endmodule
bind bbsd_core bbsd_monitor u_mon (.*);
